// ### verif/cvp_ctrl_bench.sv
`timescale 1ns/1ps
module cvp_ctrl_bench;
  // Short settling count keeps the self-test tail brief
  localparam int SETTLE = 4;
  // Clock, reset and register port
  logic              sys_clk;
  logic              reset;
  cvp_pkg::cvp_req_s req;
  logic [15:0]       rdata;
  // Comparator pins, power and converter inputs
  logic              high_cmp_pin, low_cmp_pin, hot_cmp_pin, cold_cmp_pin;
  logic              shutdown, adc_start, adc_busy;
  // Guard outputs
  logic [3:0]        cell_sense_input;
  logic [7:0]        high_dac, low_dac;
  logic [4:0]        hot_dac;
  logic [2:0]        cold_dac, therm_sel;
  logic              cmp_selftest, thermistor_reference_supply;
  logic              adc_force, adc_freeze;
  logic [15:0]       balance_stop, adc_force_value;
  // Checking state; expected read data wait in a queue
  int                n_fail, n_checks, k;
  logic [15:0]       exp_q[$];
  string             name_q[$];
  logic              rd_q;
  logic [15:0]       bs_seen, hv, lv, bl;
  logic [3:0]        lock;

  cvp_ctrl #(.SETTLE_CYC(SETTLE)) cvp_ctrl_inst (
    .sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata),
    .high_cmp_pin(high_cmp_pin), .low_cmp_pin(low_cmp_pin),
    .cell_sense_input(cell_sense_input), .high_dac(high_dac),
    .low_dac(low_dac), .cmp_selftest(cmp_selftest),
    .hot_cmp_pin(hot_cmp_pin), .cold_cmp_pin(cold_cmp_pin),
    .therm_sel(therm_sel), .hot_dac(hot_dac), .cold_dac(cold_dac),
    .thermistor_reference_supply(thermistor_reference_supply),
    .balance_stop(balance_stop), .shutdown(shutdown),
    .adc_start(adc_start), .adc_busy(adc_busy), .adc_force(adc_force),
    .adc_freeze(adc_freeze), .adc_force_value(adc_force_value));

  // Free-running 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // One comparison, counted; a mismatch is reported at once
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run, also reached when a wait runs out
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Register write: one strobe cycle beside address and data
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  // Register read: the expectation is queued, the watcher compares
  task automatic rd(logic [4:0] a, logic [15:0] e, string what);
    exp_q.push_back(e);
    name_q.push_back(what);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
  endtask

  // Let edges pass, then step off the edge so outputs have settled
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  always @(posedge sys_clk)
  begin
    if (rd_q)
    begin
      if (exp_q.size() == 0)
        check("unexpected read", 16'h0, 16'hffff);
      else
        check(name_q.pop_front(), exp_q.pop_front(), rdata);
    end
    rd_q <= req.rd;
    // Balance-stop pulses last one cycle; gather them as they pass.
    // Skipped in reset, where the output is still unknown at first
    if (!reset)
      bs_seen <= bs_seen | balance_stop;
  end

  initial
  begin
    sys_clk = 1'b0;
    reset = 1'b1;
    req = '0;
    {high_cmp_pin, low_cmp_pin, hot_cmp_pin, cold_cmp_pin} = 4'h0;
    {shutdown, adc_start, adc_busy, rd_q} = 4'h0;
    bs_seen = 16'h0;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(32'hc4124088));
    hv = 16'($urandom_range(255, 1));
    lv = 16'($urandom_range(255, 1));
    bl = 16'($urandom_range(255, 1));
    lock = 4'($urandom());
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    // Quiet after reset; unmapped places read zero and ignore writes
    wr(5'h1f, 16'hffff);
    rd(cvp_pkg::A_DEVICE_STATUS_REG, 16'h0000, "status at reset");
    rd(5'h1f, 16'h0000, "unmapped read");
    // Three active cells, cell 1 masked from the low check
    wr(cvp_pkg::A_HV_LIM, hv);
    wr(cvp_pkg::A_LV_LIM, lv);
    wr(cvp_pkg::A_BAL_LIM, bl);
    wr(cvp_pkg::A_TOP_CH, 16'h0002);
    wr(cvp_pkg::A_LMASK_A, 16'h0002);
    wr(cvp_pkg::A_LMASK_B, 16'h0000);
    high_cmp_pin <= 1'b1;
    low_cmp_pin <= 1'b1;
    wr(cvp_pkg::A_VG_CTRL, 16'h0005);
    rd(cvp_pkg::A_DEVICE_STATUS_REG, 16'h0001, "running");
    check("high dac", hv, 16'(high_dac));
    check("low dac", lv, 16'(low_dac));
    // A new limit without go must not reach the comparator
    wr(cvp_pkg::A_HV_LIM, ~hv);
    cyc(3);
    check("high dac held", hv, 16'(high_dac));
    // Second loop compares the low path against the balance limit
    cyc(1700);
    check("low dac odd loop", bl, 16'(low_dac));
    cyc(1600);
    rd(cvp_pkg::A_HVF_A, 16'h0007, "high flags a");
    rd(cvp_pkg::A_HVF_B, 16'h0000, "high flags b");
    rd(cvp_pkg::A_LVF_A, 16'h0005, "low flags a");
    rd(cvp_pkg::A_LVF_B, 16'h0000, "low flags b");
    check("balance stops", 16'h0007, bs_seen);
    // Clear the high flags once the pin is quiet
    high_cmp_pin <= 1'b0;
    cyc(6);
    wr(cvp_pkg::A_HVF_A, 16'hffff);
    rd(cvp_pkg::A_HVF_A, 16'h0000, "high flags cleared");
    // Single-channel run on a random cell
    wr(cvp_pkg::A_VG_CTRL, {8'h00, lock, 4'h7});
    cyc(300);
    check("locked cell", 16'(lock), 16'(cell_sense_input));
    wr(cvp_pkg::A_VG_CTRL, 16'h0004);
    rd(cvp_pkg::A_DEVICE_STATUS_REG, 16'h0000, "stopped");
    // Self-test entered while the converter is busy, then restarted
    adc_busy <= 1'b1;
    wr(cvp_pkg::A_VG_CTRL, 16'h0006);
    cyc(2);
    check("freeze", 16'h1, 16'(adc_freeze));
    check("self-test", 16'h1, 16'(cmp_selftest));
    adc_busy <= 1'b0;
    adc_start <= 1'b1;
    @(posedge sys_clk);
    adc_start <= 1'b0;
    cyc(2);
    check("force", 16'h1, 16'(adc_force));
    check("force value", 16'h8000, adc_force_value);
    rd(cvp_pkg::A_DEVICE_STATUS_REG, 16'h0003, "status in test");
    k = 0;
    while (cmp_selftest === 1'b1 && k < 4000)
    begin
      cyc(1);
      k++;
    end
    if (k == 4000)
    begin
      n_fail++;
      tally_and_finish();
    end
    cyc(SETTLE + 3);
    check("force released", 16'h0, 16'(adc_force));
    check("freeze released", 16'h0, 16'(adc_freeze));
    // Running guard is dropped by shutdown
    wr(cvp_pkg::A_VG_CTRL, 16'h0005);
    rd(cvp_pkg::A_DEVICE_STATUS_REG, 16'h0001, "running again");
    shutdown <= 1'b1;
    cyc(2);
    rd(cvp_pkg::A_DEVICE_STATUS_REG, 16'h0000, "after shutdown");
    shutdown <= 1'b0;
    // Temperature guard on pin 0 only, reference left off
    wr(cvp_pkg::A_TEMP_LIM, 16'h00b3);
    wr(cvp_pkg::A_PCFG_LO, 16'h0002);
    wr(cvp_pkg::A_PCFG_HI, 16'h0000);
    wr(cvp_pkg::A_TG_CTRL, 16'h0002);
    cyc(900);
    check("hot dac", 16'h0013, 16'(hot_dac));
    check("cold dac", 16'h0005, 16'(cold_dac));
    check("reference off", 16'h0, 16'(thermistor_reference_supply));
    rd(cvp_pkg::A_HOT_F, 16'h0001, "hot no ref");
    rd(cvp_pkg::A_COLD_F, 16'h0001, "cold no ref");
    // Nine 100-cycle pin slots have passed since enable: pin 1 of 8
    check("pin walk", 16'h0001, 16'(therm_sel));
    // Reference on: only the hot comparator fires
    hot_cmp_pin <= 1'b1;
    wr(cvp_pkg::A_TG_CTRL, 16'h0003);
    cyc(900);
    check("reference on", 16'h1, 16'(thermistor_reference_supply));
    wr(cvp_pkg::A_HOT_F, 16'hffff);
    wr(cvp_pkg::A_COLD_F, 16'hffff);
    cyc(900);
    rd(cvp_pkg::A_HOT_F, 16'h0001, "hot with ref");
    rd(cvp_pkg::A_COLD_F, 16'h0000, "cold with ref");
    cyc(3);
    tally_and_finish();
  end
endmodule

// ### verilog/cvp_ctrl.sv
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module cvp_ctrl #(
  parameter int SETTLE_CYC =
    (cvp_pkg::SETTLE_TIME_NS + cvp_pkg::CLK_NS - 1) / cvp_pkg::CLK_NS
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            reset,
  // Register port
  input  wire cvp_pkg::cvp_req_s req,
  output logic [15:0]          rdata,
  // Cell comparator side
  input  wire logic            high_cmp_pin,
  input  wire logic            low_cmp_pin,
  output logic [3:0]           cell_sense_input,
  output logic [7:0]           high_dac,
  output logic [7:0]           low_dac,
  output logic                 cmp_selftest,
  // Thermistor comparator side
  input  wire logic            hot_cmp_pin,
  input  wire logic            cold_cmp_pin,
  output logic [2:0]           therm_sel,
  output logic [4:0]           hot_dac,
  output logic [2:0]           cold_dac,
  output logic                 thermistor_reference_supply,
  // Balancing and power
  output logic [15:0]          balance_stop,
  input  wire logic            shutdown,
  // Converter result hold
  input  wire logic            adc_start,
  input  wire logic            adc_busy,
  output logic                 adc_force,
  output logic                 adc_freeze,
  output logic [15:0]          adc_force_value
);
  // Software registers
  logic [7:0]  high_voltage_limit;
  logic [7:0]  low_voltage_limit;
  logic [7:0]  balance_end_voltage_limit;
  logic [3:0]  top_channel_number;
  logic [7:0]  low_check_mask_a, low_check_mask_b;
  logic [1:0]  voltage_guard_mode;
  logic [3:0]  voltage_guard_channel_lock;
  logic [7:0]  temperature_limit_reg;
  logic [11:0] pcfg_lo_reg, pcfg_hi_reg;
  logic [1:0]  tg_ctrl_reg;
  // Copies taken at go
  logic [7:0]  hv_lat, lv_lat, bal_lat;
  logic [3:0]  top_lat, lock_lat;
  logic [15:0] lmask_lat;
  logic [1:0]  mode_lat;
  // Status and flags
  logic        voltage_guard_running;
  logic [15:0] high_flags, low_flags;
  logic [7:0]  hot_flags, cold_flags;
  // Sequencer
  cvp_pkg::cvp_state_e state_reg, state_next;
  logic [7:0]  slot_cnt;
  logic [3:0]  chan_reg;
  logic        phase_reg;
  logic [5:0]  bist_cnt;
  logic [7:0]  tslot_cnt;
  logic [2:0]  tchan_reg;
  logic [15:0] settle_cnt;
  logic [15:0] rdata_reg;

  // Decodes
  wire wr = req.wr;
  wire [15:0] wd = req.wdata;
  wire go = wr && req.addr == cvp_pkg::A_VG_CTRL
            && wd[cvp_pkg::GO_BIT];
  wire [1:0] go_mode = wd[cvp_pkg::MODE_LSB +: 2];
  wire slot_end = slot_cnt == 8'(cvp_pkg::SLOT_CYC - 1);
  wire tslot_end = tslot_cnt == 8'(cvp_pkg::SLOT_CYC - 1);
  wire in_round = state_reg == cvp_pkg::ST_ROUND;
  wire in_bist = state_reg == cvp_pkg::ST_BIST;
  wire in_single = state_reg == cvp_pkg::ST_SINGLE;
  wire bist_done = in_bist && slot_end
    && bist_cnt == 6'(cvp_pkg::BIST_SLOTS - 1);
  wire thermistor_reference_supply_en = tg_ctrl_reg[cvp_pkg::THERMISTOR_REFERENCE_SUPPLY_BIT];
  wire temp_en = tg_ctrl_reg[cvp_pkg::TEN_BIT];
  wire [23:0] pcfg = {pcfg_hi_reg, pcfg_lo_reg};

  // Comparator pins pass a three-stage synchroniser
  logic [3:0] s1, s2, s3, cmp_f;
  wire  [3:0] pins = {cold_cmp_pin, hot_cmp_pin,
                      low_cmp_pin, high_cmp_pin};
  always_ff @(posedge sys_clk)
  begin
    s1 <= pins;
    s2 <= s1;
    s3 <= s2;
  end
  genvar gi;
  // A bit changes only when stages two and three agree
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_filt
      always_ff @(posedge sys_clk)
      begin
        if (reset)
          cmp_f[gi] <= 1'b0;
        else if (s2[gi] == s3[gi])
          cmp_f[gi] <= s3[gi];
      end
    end
  endgenerate

  // Active cells and active thermistor pins
  logic [15:0] cell_act;
  logic [7:0]  pin_act;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_cell
      assign cell_act[gi] = 4'(gi) <= top_lat;
    end
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      assign pin_act[gi] = pcfg[3*gi +: 3]
                           == cvp_pkg::PCFG_ADC_GUARD;
    end
  endgenerate

  // Detection events, sampled at the end of each slot
  wire judge = slot_end && (in_round || in_single)
               && cell_act[chan_reg];
  wire [15:0] one_hot = 16'h0001 << chan_reg;
  wire [15:0] high_set = (judge && cmp_f[0]) ? one_hot
                         : 16'h0000;
  // Low path uses the low limit only in even loops
  wire [15:0] low_set = (judge && !phase_reg && cmp_f[1])
                        ? one_hot & ~lmask_lat
                        : 16'h0000;
  // Balance limit crossing is not a fault
  wire [15:0] bal_set = (judge && phase_reg && cmp_f[1])
                        ? one_hot : 16'h0000;
  wire tjudge = temp_en && tslot_end && pin_act[tchan_reg];
  wire [7:0] t_hot = 8'h01 << tchan_reg;
  // Without reference every judged pin shows both faults
  wire [7:0] hot_set = (tjudge && (!thermistor_reference_supply_en || cmp_f[2]))
                       ? t_hot : 8'h00;
  wire [7:0] cold_set = (tjudge && (!thermistor_reference_supply_en || cmp_f[3]))
                        ? t_hot : 8'h00;

  // Write-one-to-clear masks for the flags
  wire [15:0] hv_clr = {wr && req.addr == cvp_pkg::A_HVF_B ? wd[7:0]
    : 8'h00, wr && req.addr == cvp_pkg::A_HVF_A ? wd[7:0] : 8'h00};
  wire [15:0] lv_clr = {wr && req.addr == cvp_pkg::A_LVF_B ? wd[7:0]
    : 8'h00, wr && req.addr == cvp_pkg::A_LVF_A ? wd[7:0] : 8'h00};
  wire [7:0] hot_clr = wr && req.addr == cvp_pkg::A_HOT_F
                       ? wd[7:0] : 8'h00;
  wire [7:0] cold_clr = wr && req.addr == cvp_pkg::A_COLD_F
                        ? wd[7:0] : 8'h00;

  // Plain software registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      high_voltage_limit <= 8'h00;
      low_voltage_limit <= 8'h00;
      balance_end_voltage_limit <= 8'h00;
      top_channel_number <= 4'h0;
      low_check_mask_a <= 8'h00;
      low_check_mask_b <= 8'h00;
      voltage_guard_mode <= cvp_pkg::MODE_STOP;
      voltage_guard_channel_lock <= 4'h0;
      temperature_limit_reg <= 8'h00;
      pcfg_lo_reg <= 12'h000;
      pcfg_hi_reg <= 12'h000;
      tg_ctrl_reg <= 2'h0;
    end
    else if (wr)
    begin
      unique case (req.addr)
        cvp_pkg::A_HV_LIM:   high_voltage_limit <= wd[7:0];
        cvp_pkg::A_LV_LIM:   low_voltage_limit <= wd[7:0];
        cvp_pkg::A_BAL_LIM:  balance_end_voltage_limit <= wd[7:0];
        cvp_pkg::A_TOP_CH:   top_channel_number <= wd[3:0];
        cvp_pkg::A_LMASK_A:  low_check_mask_a <= wd[7:0];
        cvp_pkg::A_LMASK_B:  low_check_mask_b <= wd[7:0];
        cvp_pkg::A_VG_CTRL:
        begin
          voltage_guard_mode <= go_mode;
          voltage_guard_channel_lock <= wd[cvp_pkg::LOCK_LSB +: 4];
        end
        cvp_pkg::A_TEMP_LIM: temperature_limit_reg <= wd[7:0];
        cvp_pkg::A_PCFG_LO:  pcfg_lo_reg <= wd[11:0];
        cvp_pkg::A_PCFG_HI:  pcfg_hi_reg <= wd[11:0];
        cvp_pkg::A_TG_CTRL:  tg_ctrl_reg <= wd[1:0];
        default: ;
      endcase
    end
  end

  // Settings take effect only when go is written
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      hv_lat <= 8'h00;
      lv_lat <= 8'h00;
      bal_lat <= 8'h00;
      top_lat <= 4'h0;
      lmask_lat <= 16'h0000;
      mode_lat <= cvp_pkg::MODE_STOP;
      lock_lat <= 4'h0;
    end
    else if (go)
    begin
      hv_lat <= high_voltage_limit;
      lv_lat <= low_voltage_limit;
      bal_lat <= balance_end_voltage_limit;
      top_lat <= top_channel_number;
      lmask_lat <= {low_check_mask_b, low_check_mask_a};
      mode_lat <= go_mode;
      lock_lat <= wd[cvp_pkg::LOCK_LSB +: 4];
    end
  end

  // Mode decode on go; shutdown stops the guard
  always_comb
  begin
    state_next = state_reg;
    if (shutdown)
      state_next = cvp_pkg::ST_IDLE;
    else if (go)
    begin
      unique case (go_mode)
        cvp_pkg::MODE_ROUND:  state_next = cvp_pkg::ST_ROUND;
        cvp_pkg::MODE_BIST:   state_next = cvp_pkg::ST_BIST;
        cvp_pkg::MODE_SINGLE: state_next = cvp_pkg::ST_SINGLE;
        default:              state_next = cvp_pkg::ST_IDLE;
      endcase
    end
    else if (bist_done)
      state_next = cvp_pkg::ST_IDLE;
  end

  // State and running flag
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      state_reg <= cvp_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end
  assign voltage_guard_running = state_reg != cvp_pkg::ST_IDLE;

  // Slot timer runs for every cell alike
  always_ff @(posedge sys_clk)
  begin
    if (reset || go || slot_end)
      slot_cnt <= 8'h00;
    else
      slot_cnt <= slot_cnt + 8'h01;
  end

  // Channel walk over all sixteen cells and loop parity
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      chan_reg <= 4'h0;
      phase_reg <= 1'b0;
    end
    else if (go)
    begin
      chan_reg <= go_mode == cvp_pkg::MODE_SINGLE
                  ? wd[cvp_pkg::LOCK_LSB +: 4] : 4'h0;
      phase_reg <= 1'b0;
    end
    else if (in_round && slot_end)
    begin
      chan_reg <= chan_reg + 4'h1;
      if (chan_reg == 4'hf)
        phase_reg <= !phase_reg;
    end
  end

  // Self-test slot counter
  always_ff @(posedge sys_clk)
  begin
    if (reset || go)
      bist_cnt <= 6'h00;
    else if (in_bist && slot_end)
      bist_cnt <= bist_cnt + 6'h01;
  end

  // Thermistor walk over all eight pins
  always_ff @(posedge sys_clk)
  begin
    if (reset || !temp_en || tslot_end)
      tslot_cnt <= 8'h00;
    else
      tslot_cnt <= tslot_cnt + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset || !temp_en)
      tchan_reg <= 3'h0;
    else if (tslot_end)
      tchan_reg <= tchan_reg + 3'h1;
  end

  // Sticky flags: a set in the clear cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      high_flags <= 16'h0000;
      low_flags <= 16'h0000;
      hot_flags <= 8'h00;
      cold_flags <= 8'h00;
    end
    else
    begin
      high_flags <= (high_flags & ~hv_clr) | high_set;
      low_flags <= (low_flags & ~lv_clr) | low_set;
      hot_flags <= (hot_flags & ~hot_clr) | hot_set;
      cold_flags <= (cold_flags & ~cold_clr) | cold_set;
    end
  end

  // Converter hold while self-test runs and until settled after its last slot
  wire bist_start = go && go_mode == cvp_pkg::MODE_BIST;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      adc_force <= 1'b0;
      adc_freeze <= 1'b0;
      settle_cnt <= 16'h0000;
    end
    else
    begin
      if (bist_start && adc_busy)
        adc_freeze <= 1'b1;
      if (in_bist && adc_start)
        adc_force <= 1'b1;
      if (bist_done)
        settle_cnt <= 16'(SETTLE_CYC);
      else if (settle_cnt != 16'h0000 && !in_bist)
      begin
        settle_cnt <= settle_cnt - 16'h0001;
        if (settle_cnt == 16'h0001)
        begin
          adc_force <= 1'b0;
          adc_freeze <= 1'b0;
        end
      end
    end
  end
  assign adc_force_value = cvp_pkg::ADC_BIST_VALUE;

  // Cell comparator drive from latched settings; thermistor side straight from its registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      low_dac <= 8'h00;
      balance_stop <= 16'h0000;
    end
    else
    begin
      low_dac <= phase_reg ? bal_lat : lv_lat;
      balance_stop <= bal_set;
    end
  end
  assign high_dac = hv_lat;
  assign cell_sense_input = chan_reg;
  assign cmp_selftest = in_bist;
  assign therm_sel = tchan_reg;
  assign hot_dac = temperature_limit_reg[cvp_pkg::HOT_LSB +: 5];
  assign cold_dac = temperature_limit_reg[cvp_pkg::COLD_LSB +: 3];
  assign thermistor_reference_supply = thermistor_reference_supply_en;

  // Read multiplexer, unmapped reads give zero
  logic [15:0] rmux;
  always_comb
  begin
    unique case (req.addr)
      cvp_pkg::A_HV_LIM:   rmux = {8'h00, high_voltage_limit};
      cvp_pkg::A_LV_LIM:   rmux = {8'h00, low_voltage_limit};
      cvp_pkg::A_BAL_LIM:  rmux = {8'h00, balance_end_voltage_limit};
      cvp_pkg::A_TOP_CH:   rmux = {12'h000, top_channel_number};
      cvp_pkg::A_LMASK_A:  rmux = {8'h00, low_check_mask_a};
      cvp_pkg::A_LMASK_B:  rmux = {8'h00, low_check_mask_b};
      cvp_pkg::A_VG_CTRL:  rmux = {8'h00, voltage_guard_channel_lock,
                                   2'h0, voltage_guard_mode};
      cvp_pkg::A_DEVICE_STATUS_REG: rmux = {14'h0000, in_bist,
                                   voltage_guard_running};
      cvp_pkg::A_HVF_A:    rmux = {8'h00, high_flags[7:0]};
      cvp_pkg::A_HVF_B:    rmux = {8'h00, high_flags[15:8]};
      cvp_pkg::A_LVF_A:    rmux = {8'h00, low_flags[7:0]};
      cvp_pkg::A_LVF_B:    rmux = {8'h00, low_flags[15:8]};
      cvp_pkg::A_TEMP_LIM: rmux = {8'h00, temperature_limit_reg};
      cvp_pkg::A_PCFG_LO:  rmux = {4'h0, pcfg_lo_reg};
      cvp_pkg::A_PCFG_HI:  rmux = {4'h0, pcfg_hi_reg};
      cvp_pkg::A_TG_CTRL:  rmux = {14'h0000, tg_ctrl_reg};
      cvp_pkg::A_HOT_F:    rmux = {8'h00, hot_flags};
      cvp_pkg::A_COLD_F:   rmux = {8'h00, cold_flags};
      default:             rmux = 16'h0000;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset || !req.rd)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rmux;
  end
  assign rdata = rdata_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_RUN_SET: assert property (
    go && go_mode != cvp_pkg::MODE_STOP && !shutdown
    |=> voltage_guard_running)
    else $error("running flag not set after go");
  AST_RUN_CLR: assert property (
    go && go_mode == cvp_pkg::MODE_STOP |=> !voltage_guard_running)
    else $error("running flag not cleared by stop");
  AST_INACTIVE: assert property (
    (high_set & ~cell_act) == 16'h0000
    && (low_set & ~cell_act) == 16'h0000)
    else $error("fault set on inactive cell");
  AST_LOW_MASK: assert property (
    (low_set & lmask_lat) == 16'h0000
    ##1 (low_flags & ~$past(low_flags) & $past(lmask_lat)) == 16'h0000)
    else $error("masked cell got low flag");
  AST_FORCE: assert property (
    in_bist && adc_start
    |=> adc_force && adc_force_value == 16'h8000)
    else $error("converter not forced during self-test");
  AST_FREEZE: assert property (
    bist_start && adc_busy && !shutdown |=> adc_freeze [*2])
    else $error("converter not frozen");
  AST_SINGLE: assert property (
    in_single && !go |=> cell_sense_input == lock_lat)
    else $error("single mode left locked cell");
  AST_LATCH: assert property (
    !go |=> $stable(hv_lat) && $stable(mode_lat) && $stable(lmask_lat))
    else $error("settings changed without go");
  AST_SLOT: assert property (
    in_round && slot_end && !go
    |=> chan_reg == $past(chan_reg) + 4'h1 && slot_cnt == 8'h00)
    else $error("round slot did not advance");
  AST_NO_REF: assert property (
    tjudge && !thermistor_reference_supply_en
    |=> hot_flags[$past(tchan_reg)] && cold_flags[$past(tchan_reg)])
    else $error("missing reference not flagged");
  CV_ROUND: cover property (in_round && judge && cmp_f[0]);
  CV_BAL: cover property (bal_set != 16'h0000);
  CV_BIST: cover property (bist_done);
  CV_SINGLE: cover property (in_single && slot_end);
endmodule

// ### verilog/cvp_pkg.sv
package cvp_pkg;
  // Register bus widths, cell and pin counts
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NCELL  = 16;
  localparam int NGPIO  = 8;
  // Register offsets (word index on the plain port)
  localparam logic [4:0] A_HV_LIM   = 5'h00;
  localparam logic [4:0] A_LV_LIM   = 5'h01;
  localparam logic [4:0] A_BAL_LIM  = 5'h02;
  localparam logic [4:0] A_TOP_CH   = 5'h03;
  localparam logic [4:0] A_LMASK_A  = 5'h04;
  localparam logic [4:0] A_LMASK_B  = 5'h05;
  localparam logic [4:0] A_VG_CTRL  = 5'h06;
  localparam logic [4:0] A_DEVICE_STATUS_REG = 5'h07;
  localparam logic [4:0] A_HVF_A    = 5'h08;
  localparam logic [4:0] A_HVF_B    = 5'h09;
  localparam logic [4:0] A_LVF_A    = 5'h0a;
  localparam logic [4:0] A_LVF_B    = 5'h0b;
  localparam logic [4:0] A_TEMP_LIM = 5'h0c;
  localparam logic [4:0] A_PCFG_LO  = 5'h0d;
  localparam logic [4:0] A_PCFG_HI  = 5'h0e;
  localparam logic [4:0] A_TG_CTRL  = 5'h0f;
  localparam logic [4:0] A_HOT_F    = 5'h10;
  localparam logic [4:0] A_COLD_F   = 5'h11;
  // Control field positions
  localparam int MODE_LSB = 0;
  localparam int GO_BIT   = 2;
  localparam int LOCK_LSB = 4;
  localparam int HOT_LSB  = 0;
  localparam int COLD_LSB = 5;
  localparam int THERMISTOR_REFERENCE_SUPPLY_BIT = 0;
  localparam int TEN_BIT   = 1;
  // Mode encodings
  localparam logic [1:0] MODE_STOP   = 2'h0;
  localparam logic [1:0] MODE_ROUND  = 2'h1;
  localparam logic [1:0] MODE_BIST   = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  // Pin configuration code for combined converter and guard input
  localparam logic [2:0] PCFG_ADC_GUARD = 3'h2;
  localparam logic [15:0] ADC_BIST_VALUE = 16'h8000;
  // Timing
  localparam int CLK_NS       = 4;
  localparam int SLOT_TIME_NS = 400;
  localparam int SLOT_CYC = (SLOT_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIST_SLOTS   = 32;
  localparam int SETTLE_TIME_NS = 10000;
  // Register bus request
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } cvp_req_s;
  // Guard sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ROUND  = 4'b0010,
    ST_BIST   = 4'b0100,
    ST_SINGLE = 4'b1000
  } cvp_state_e;
endpackage
